// *** rtl/cic_pkg.sv ***
// constants for the cascaded interrupt controller
// assumes a single peripheral clock and an active-low system reset
// Contract
// R1: two controller modules, slave output feeds one master request input.
// R2: ten external pins and eight internal requests enter the controllers.
// R3: one pending bit per request input, set when that request asserts.
// R4: software selects active-high level or rising-edge sensing per input; code ignores the mode of master input 2, the cascade line.
// R5: highest-priority pending request wins and drives the one core request line.
// R6: after reset, master input zero ranks highest, input seven lowest.
// R7: software may move the priority order away from the default.
// R8: external controllers cascade only on the four lowest external pins.
// R9: outside logic decodes acknowledge from address strobe and status lines.
// R10: write/read status high on write cycles, low on read cycles.
// R11: acknowledge gives winner's vector, clears pending, marks in service.
package cic_pkg;
    localparam int          LINES       = 8;
    localparam int          IDX_W       = 3;
    localparam int          EXT_PINS    = 10;
    localparam int          INT_REQS    = 8;
    localparam int          CASC_PINS   = 4;
    localparam int          MST         = 0;
    localparam int          SLV         = 1;
    localparam logic [2:0]  CASC_LINE   = 3'h2;
    localparam logic [2:0]  PRIO_RST    = 3'h0;
    localparam logic [7:0]  EDGE_RST    = 8'h00;
    localparam logic [7:0]  VEC_BASE_M  = 8'h20;
    localparam logic [7:0]  VEC_BASE_S  = 8'h28;
    localparam logic [7:0]  VEC_RST     = 8'h00;
    localparam logic [7:0]  LINE_MASK   = 8'h07;
    localparam logic [1:0]  SYNC_RST    = 2'h0;
    localparam logic [1:0]  SYNC_ONE    = 2'h1;
endpackage : cic_pkg

// *** rtl/cic_top.sv ***
// two-controller cascaded interrupt unit with vectored acknowledge
// assumes all inputs but rst_b synchronous to core_clk; ack and eoi are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module cic_top (
    input  wire logic        core_clk,         // peripheral clock
    input  wire logic        rst_b,            // async reset, active low
    input  wire logic [9:0]  ext_req,          // external_request_pins, low four cascade_request_pins
    input  wire logic [7:0]  int_req,          // internal peripheral requests
    input  wire logic        cfg_load,         // pulse: take edge modes and priority bases
    input  wire logic [7:0]  edge_mode_m,      // master: 1 edge, 0 level; bit 2 (cascade line) has no effect
    input  wire logic [7:0]  edge_mode_s,      // slave: 1 edge, 0 level
    input  wire logic [2:0]  prio_base_m,      // master line ranked highest
    input  wire logic [2:0]  prio_base_s,      // slave line ranked highest
    input  wire logic        ack,              // pulse: core acknowledge
    input  wire logic        eoi_m,            // pulse: end of service, master
    input  wire logic        eoi_s,            // pulse: end of service, slave
    input  wire logic        cyc_write,        // core bus cycle is a write
    output logic             core_irq,         // request line to the core
    output logic [7:0]       vector,           // vector of acknowledged request
    output logic             vector_valid,     // pulse: vector holds
    output logic [7:0]       in_service_m,     // master in-service bits
    output logic [7:0]       in_service_s,     // slave in-service bits
    output logic             write_read        // high write, low read
);
    typedef struct packed {
        logic [1:0][7:0] edge_mode;
        logic [1:0][2:0] prio_base;
        logic [1:0][7:0] prev;
        logic [1:0][7:0] latch;
        logic [1:0][7:0] isr;
        logic            irq;
        logic [7:0]      vec;
        logic            vec_ok;
        logic            wr;
    } cic_state_t;

    localparam int IDX_W_L = cic_pkg::IDX_W;

    cic_state_t       st_r;
    cic_state_t       st_nxt;
    logic [1:0]       rst_sync_r;
    logic             rst_n;
    logic [1:0][7:0]  raw;
    logic [1:0][7:0]  pend;
    logic [IDX_W_L:0] pick_pm;
    logic [IDX_W_L:0] pick_im;
    logic [IDX_W_L:0] pick_ps;
    logic [IDX_W_L:0] pick_is;
    logic             slave_out;
    logic             master_go;

    // rank of a line relative to the highest-priority line
    function automatic logic [2:0] rank(input logic [2:0] idx, input logic [2:0] base);
        rank = idx - base;
    endfunction : rank

    // highest-ranked set bit: {found, index}
    function automatic logic [3:0] pick(input logic [7:0] req, input logic [2:0] base);
        logic [2:0] i;
        pick = 4'h0;
        for (int k = cic_pkg::LINES - 1; k >= 0; k--) begin
            i = base + 3'(k);
            if (req[i]) begin
                pick = {1'b1, i};
            end
        end
    endfunction : pick

    // true when the pending pick outranks everything in service
    function automatic logic allow(input logic [3:0] p, input logic [3:0] s,
                                   input logic [2:0] base);
        allow = p[3] && (!s[3] || (rank(p[2:0], base) < rank(s[2:0], base)));
    endfunction : allow

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= cic_pkg::SYNC_RST;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // line map: master 0,1,3,4 cascade pins, 5..7 ext 4..6; slave 0..4 int 0..4,
    // slave 5..7 ext 7..9 shared with int 5..7
    always_comb begin
        raw[cic_pkg::MST] = {ext_req[6:4], ext_req[3:2], slave_out, ext_req[1:0]}; // R2 R8 R1
        raw[cic_pkg::SLV] = {ext_req[9:7] | int_req[7:5], int_req[4:0]};             // R2
    end

    // level lines follow the input, edge lines use the latch
    for (genvar c = 0; c < 2; c++) begin : g_pend
        for (genvar l = 0; l < cic_pkg::LINES; l++) begin : g_line
            // cascade line always follows the slave output, whatever its mode
            if (c == cic_pkg::MST && l == int'(cic_pkg::CASC_LINE)) begin : g_casc
                assign pend[c][l] = raw[c][l];                                     // R1
            end else begin : g_norm
                assign pend[c][l] = st_r.edge_mode[c][l] ? st_r.latch[c][l] : raw[c][l]; // R3 R4
            end
        end
    end

    always_comb begin
        pick_ps   = pick(pend[cic_pkg::SLV], st_r.prio_base[cic_pkg::SLV]);
        pick_is   = pick(st_r.isr[cic_pkg::SLV], st_r.prio_base[cic_pkg::SLV]);
        slave_out = allow(pick_ps, pick_is, st_r.prio_base[cic_pkg::SLV]);          // R1 R5
        pick_pm   = pick(pend[cic_pkg::MST], st_r.prio_base[cic_pkg::MST]);
        pick_im   = pick(st_r.isr[cic_pkg::MST], st_r.prio_base[cic_pkg::MST]);
        master_go = allow(pick_pm, pick_im, st_r.prio_base[cic_pkg::MST]);          // R5
    end

    always_comb begin
        st_nxt        = st_r;
        st_nxt.vec_ok = 1'b0;
        st_nxt.wr     = cyc_write;                                                 // R10
        st_nxt.prev   = raw;
        if (cfg_load) begin
            st_nxt.edge_mode[cic_pkg::MST] = edge_mode_m;                          // R4
            st_nxt.edge_mode[cic_pkg::SLV] = edge_mode_s;                          // R4
            st_nxt.prio_base[cic_pkg::MST] = prio_base_m;                          // R7
            st_nxt.prio_base[cic_pkg::SLV] = prio_base_s;                          // R7
        end
        if (eoi_m && pick_im[3]) begin
            st_nxt.isr[cic_pkg::MST][pick_im[2:0]] = 1'b0;
        end
        if (eoi_s && pick_is[3]) begin
            st_nxt.isr[cic_pkg::SLV][pick_is[2:0]] = 1'b0;
        end
        if (ack && master_go) begin
            st_nxt.vec_ok                          = 1'b1;
            st_nxt.isr[cic_pkg::MST][pick_pm[2:0]] = 1'b1;                         // R11
            st_nxt.latch[cic_pkg::MST][pick_pm[2:0]] = 1'b0;                       // R11
            st_nxt.vec = cic_pkg::VEC_BASE_M | {5'h00, pick_pm[2:0]};              // R11
            if (pick_pm[2:0] == cic_pkg::CASC_LINE) begin
                st_nxt.isr[cic_pkg::SLV][pick_ps[2:0]]   = 1'b1;                   // R11
                st_nxt.latch[cic_pkg::SLV][pick_ps[2:0]] = 1'b0;                   // R11
                st_nxt.vec = cic_pkg::VEC_BASE_S | {5'h00, pick_ps[2:0]};          // R11
            end
        end
        // new rising edge wins over an acknowledge clear in the same cycle
        // only edge lines latch, so a switch from level to edge finds no stale bits
        st_nxt.latch = st_nxt.latch | (raw & ~st_r.prev & st_r.edge_mode);         // R3
        st_nxt.latch[cic_pkg::MST][cic_pkg::CASC_LINE] = 1'b0;
        st_nxt.irq   = master_go && !(ack && master_go);                           // R5
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.edge_mode <= {cic_pkg::EDGE_RST, cic_pkg::EDGE_RST};
            st_r.prio_base <= {cic_pkg::PRIO_RST, cic_pkg::PRIO_RST};              // R6
            st_r.prev      <= {cic_pkg::EDGE_RST, cic_pkg::EDGE_RST};
            st_r.latch     <= {cic_pkg::EDGE_RST, cic_pkg::EDGE_RST};
            st_r.isr       <= {cic_pkg::EDGE_RST, cic_pkg::EDGE_RST};
            st_r.irq       <= 1'b0;
            st_r.vec       <= cic_pkg::VEC_RST;
            st_r.vec_ok    <= 1'b0;
            st_r.wr        <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign core_irq     = st_r.irq;
    assign vector       = st_r.vec;
    assign vector_valid = st_r.vec_ok;
    assign in_service_m = st_r.isr[cic_pkg::MST];
    assign in_service_s = st_r.isr[cic_pkg::SLV];
    assign write_read   = st_r.wr;                                                 // R10
endmodule : cic_top
`default_nettype wire

// *** tb/cic_core_model.sv ***
// core side model: acks raised requests, then ends service; drives on falling edges
`timescale 1ns/100ps
`default_nettype none
module cic_core_model (
    input  wire logic       core_clk, core_irq, // clock, unit request
    input  wire logic [7:0] vector,             // acknowledged vector
    output logic            ack, eoi_m, eoi_s   // acknowledge, end of service
);
    initial {ack, eoi_m, eoi_s} = 3'h0;
    always begin
        @(negedge core_clk iff core_irq);
        repeat ($urandom_range(3, 1)) @(negedge core_clk);
        ack = 1'b1;
        @(negedge core_clk) ack = 1'b0;
        repeat ($urandom_range(5, 2)) @(negedge core_clk);
        eoi_s = vector[3];
        @(negedge core_clk) {eoi_s, eoi_m} = 2'h1;
        @(negedge core_clk) eoi_m = 1'b0;
    end
endmodule : cic_core_model
`default_nettype wire

// *** tb/cic_top_asserts.sv ***
// assertions on cic_top ports; assumes one clock, rst_b active low
`timescale 1ns/100ps
`default_nettype none
module cic_top_asserts (
    input wire logic       core_clk, rst_b, ack, cyc_write, // clock, reset, inputs
    input wire logic       core_irq, vector_valid, write_read, // outputs
    input wire logic [7:0] vector, in_service_m // outputs
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_WR_RISE: assert property ($rose(write_read) |-> $past(cyc_write)) else $error("dir");
    AST_WR_FALL: assert property ($fell(write_read) |-> !$past(cyc_write)) else $error("dir");
    AST_VV_CAUSE: assert property (vector_valid |-> $past(ack)) else $error("no ack");
    AST_IRQ_DROP: assert property (vector_valid |-> !core_irq) else $error("irq held");
    AST_VEC_BASE: assert property (vector_valid |-> vector[7:4] == 4'h2) else $error("base");
    AST_ISR_M: assert property (vector_valid && !vector[3] |-> in_service_m[vector[2:0]])
        else $error("isr");
    AST_ISR_S: assert property (vector_valid && vector[3] |-> in_service_m[2]) else $error("casc");
    AST_VEC_HOLD: assert property (!vector_valid |-> $stable(vector)) else $error("vec");
endmodule : cic_top_asserts
bind cic_top cic_top_asserts CHK (.*);
`default_nettype wire

// *** tb/cic_top_bench.sv ***
// random request bench for cic_top; assumes cic_core_model serves requests
`timescale 1ns/100ps
`default_nettype none
module cic_top_bench;
    logic core_clk = 0, rst_b = 0, cfg_load = 0, cyc_write = 0;
    logic [9:0] ext_req = '0;
    logic [7:0] int_req = '0, edge_mode_m = '0, edge_mode_s = '0;
    logic [2:0] prio_base_m = '0, prio_base_s = '0;
    wire logic ack, eoi_m, eoi_s, core_irq, vector_valid, write_read;
    wire logic [7:0] vector, in_service_m, in_service_s;
    int n_mismatch = 0, check_count = 0, z;
    cic_top DUT (.*);
    cic_core_model CORE (.*);
    always #5 core_clk = ~core_clk;
    always @(negedge core_clk) cyc_write <= 1'($urandom);
    function automatic logic [7:0] exp_vec(logic [17:0] r, logic [2:0] bm, bs);
        logic [7:0] s = r[7:0] | {r[17:15], 5'h00};
        logic [7:0] m = {r[14:12], r[11:10], |s, r[9:8]};
        logic [2:0] k = 3'h0;
        for (int n = 7; n >= 0; n--) if (m[bm + 3'(n)]) k = bm + 3'(n);
        if (k != cic_pkg::CASC_LINE) return cic_pkg::VEC_BASE_M + 8'(k);
        for (int n = 7; n >= 0; n--) if (s[bs + 3'(n)]) k = bs + 3'(n);
        return cic_pkg::VEC_BASE_S + 8'(k);
    endfunction : exp_vec
    task automatic chk(input logic [7:0] got, exp);
        check_count++;
        if (got !== exp) n_mismatch++;
        if (got !== exp) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    endtask : chk
    task automatic finish_test(input int extra);
        n_mismatch += extra;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial #100000 finish_test(1);
    initial begin
        void'($urandom(32'h2AD442A1));
        for (int i = 0; i < 13; i++) @(negedge core_clk) rst_b = i > 9;
        for (int t = 0; t < 60; t++) begin
            {edge_mode_m, edge_mode_s, prio_base_m, prio_base_s} = t ? 22'($urandom) : 22'h0;
            cfg_load = 1'b1;
            @(negedge core_clk) cfg_load = 1'b0;
            {ext_req, int_req} = t ? 18'($urandom) | 18'h1 : 18'h3FC00;
            for (int w = 0; w < 20 && !vector_valid; w++) @(negedge core_clk);
            chk(vector, exp_vec({ext_req, int_req}, prio_base_m, prio_base_s));
            {ext_req, int_req} = 18'h0;
            for (z = 0; z < 8; z = core_irq || |in_service_m ? 0 : z + 1) @(negedge core_clk);
        end
        finish_test(0);
    end
endmodule : cic_top_bench
`default_nettype wire
